// ---- src/power_mode_map.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the power and mode control.
 * Assumes it is included by bare name from the power mode control design file.
 */
`ifndef POWER_MODE_MAP_SVH
`define POWER_MODE_MAP_SVH

`define PWR_CTRL_ADDR      8'h87
`define PWR_CTRL_RESET     8'h00
`define BIT_BAUD_DOUBLE    7
`define BIT_SER7_SELECT    6
`define BIT_POWER_OFF      5
`define BIT_WDOG_LOAD_EN   4
`define BIT_GEN_FLAG_HI    3
`define BIT_GEN_FLAG_LO    2
`define BIT_POWERDOWN_SEL  1
`define BIT_IDLE_SEL       0
`define IDLE_GUARD_CYCLES  12

`endif

// ---- src/power_mode_pkg.sv ----
/*
 * Types shared by the power and mode control files.
 * Assumes the map header sits beside it.
 */
package power_mode_pkg;
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_POWERDOWN
    } power_mode_e;

    typedef struct packed {
        logic strobe;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic baud_double;
        logic serial_bit7_select;
        logic power_off_flag;
        logic watchdog_load_enable;
        logic general_flag_hi;
        logic general_flag_lo;
        logic powerdown_select;
        logic idle_select;
    } power_control_s;
endpackage : power_mode_pkg

// ---- src/emulation_entry.sv ----
/*
 * Samples the emulation entry condition at reset release and holds the mode.
 * Assumes the strobe inputs are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module emulation_entry (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic latch_strobe_i,
    input  wire logic program_store_strobe_i,
    output var  logic emulation_o
);
    logic in_reset_q;

    // Marks the first edge after reset release, where the entry pins are sampled.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_reset_q <= 1'b1;
        end else begin
            in_reset_q <= 1'b0;
        end
    end

    // Latch the mode at the first edge after release; only a clean reset clears it.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            emulation_o <= 1'b0;
        end else if (in_reset_q) begin
            emulation_o <= !latch_strobe_i && program_store_strobe_i;
        end
    end
endmodule : emulation_entry
`default_nettype wire

// ---- src/power_mode_control.sv ----
/*
 * Power control register, idle and power-down sequencing, emulation mode pin control
 * and address latch strobe suppression.
 * Assumes a CPU special function register port synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_map.svh"
module power_mode_control
    import power_mode_pkg::*;
#(
    parameter int IDLE_GUARD = `IDLE_GUARD_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire sfr_req_s   sfr_i,
    output logic [7:0]      sfr_rdata_o,
    output logic            sfr_hit_o,
    input  wire logic       watchdog_enable_i,
    input  wire logic       powerdown_wake_enable_i,
    input  wire logic       watchdog_timer_load_i,
    input  wire logic       power_up_detect_i,
    input  wire logic       interrupt_pending_i,
    input  wire logic       ext_interrupt_i,
    input  wire logic       hw_reset_req_i,
    input  wire logic       latch_strobe_off_i,
    input  wire logic       ext_mem_access_i,
    input  wire logic       latch_strobe_i,
    input  wire logic       program_store_strobe_i,
    input  wire logic [1:0] serial_mode_i,
    output logic            baud_double_o,
    output logic            serial_bit7_select_o,
    output logic            cpu_halt_o,
    output logic            osc_stop_o,
    output logic            ram_write_block_o,
    output logic            emulation_o,
    output logic            port0_float_o,
    output logic            weak_pullup_o,
    output logic            latch_strobe_en_o
);
    // ------------------------------------------------------------
    // Register and mode state
    // ------------------------------------------------------------
    power_control_s pc_q;
    power_mode_e    mode_q;
    logic [7:0]     guard_q;
    logic           emul_w;
    logic           wr_hit;
    power_control_s wv;

    assign wr_hit = sfr_i.strobe && sfr_i.write && (sfr_i.addr == `PWR_CTRL_ADDR);
    assign wv     = power_control_s'(sfr_i.wdata);

    // Writable fields, with hardware effects taking priority where they set.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_q <= power_control_s'(`PWR_CTRL_RESET);
        end else begin
            if (wr_hit) begin
                pc_q.baud_double          <= wv.baud_double;
                pc_q.serial_bit7_select   <= wv.serial_bit7_select;
                pc_q.general_flag_hi      <= wv.general_flag_hi;
                pc_q.general_flag_lo      <= wv.general_flag_lo;
                pc_q.power_off_flag       <= wv.power_off_flag;
                pc_q.watchdog_load_enable <= wv.watchdog_load_enable;
                pc_q.idle_select          <= wv.idle_select && !(wv.powerdown_select
                                             && !watchdog_enable_i);
                if (!watchdog_enable_i || !wv.powerdown_select) begin
                    pc_q.powerdown_select <= wv.powerdown_select;
                end
            end
            if (watchdog_timer_load_i) begin
                pc_q.watchdog_load_enable <= 1'b0;
            end
            if (power_up_detect_i) begin
                pc_q.power_off_flag <= 1'b1;
            end
            if (mode_q == MODE_IDLE && interrupt_pending_i) begin
                pc_q.idle_select <= 1'b0;
            end
            if (mode_q == MODE_POWERDOWN && ext_interrupt_i && powerdown_wake_enable_i) begin
                pc_q.powerdown_select <= 1'b0;
            end
        end
    end

    // Mode sequencer following the select bits and wake events.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= MODE_RUN;
        end else begin
            case (mode_q)
                MODE_RUN: begin
                    if (pc_q.powerdown_select) begin
                        mode_q <= MODE_POWERDOWN;
                    end else if (pc_q.idle_select) begin
                        mode_q <= MODE_IDLE;
                    end
                end
                MODE_IDLE: begin
                    if (interrupt_pending_i) begin
                        mode_q <= MODE_RUN;
                    end
                end
                MODE_POWERDOWN: begin
                    if (ext_interrupt_i && powerdown_wake_enable_i) begin
                        mode_q <= MODE_RUN;
                    end
                end
                default: mode_q <= MODE_RUN;
            endcase
        end
    end

    // Guard window after a reset request in idle: RAM writes blocked for IDLE_GUARD cycles after the request drops.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            guard_q <= 8'h00;
        end else if (mode_q == MODE_IDLE && hw_reset_req_i) begin
            guard_q <= 8'(IDLE_GUARD);
        end else if (guard_q != 8'h00) begin
            guard_q <= guard_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Emulation entry
    // ------------------------------------------------------------
    emulation_entry u_emul (
        .clk_i                  (clk_i),
        .rstn_i                 (rstn_i),
        .latch_strobe_i         (latch_strobe_i),
        .program_store_strobe_i (program_store_strobe_i),
        .emulation_o            (emul_w)
    );

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // All outputs are taken from flip-flops.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_rdata_o          <= 8'h00;
            sfr_hit_o            <= 1'b0;
            baud_double_o        <= 1'b0;
            serial_bit7_select_o <= 1'b0;
            cpu_halt_o           <= 1'b0;
            osc_stop_o           <= 1'b0;
            ram_write_block_o    <= 1'b0;
            emulation_o          <= 1'b0;
            port0_float_o        <= 1'b0;
            weak_pullup_o        <= 1'b0;
            latch_strobe_en_o    <= 1'b0;
        end else begin
            sfr_hit_o            <= sfr_i.strobe && !sfr_i.write && sfr_i.addr == `PWR_CTRL_ADDR;
            sfr_rdata_o          <= (sfr_i.addr == `PWR_CTRL_ADDR) ? 8'(pc_q) : 8'h00;
            baud_double_o        <= pc_q.baud_double && (serial_mode_i != 2'b00);
            serial_bit7_select_o <= pc_q.serial_bit7_select;
            cpu_halt_o           <= (mode_q != MODE_RUN);
            osc_stop_o           <= (mode_q == MODE_POWERDOWN) && !emul_w;
            ram_write_block_o    <= (guard_q != 8'h00) || (mode_q == MODE_IDLE
                                    && hw_reset_req_i);
            emulation_o          <= emul_w;
            port0_float_o        <= emul_w;
            weak_pullup_o        <= emul_w;
            latch_strobe_en_o    <= !emul_w && (!latch_strobe_off_i
                                    || ext_mem_access_i);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pd_blocked_wde: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_hit && wv.powerdown_select && watchdog_enable_i && !pc_q.powerdown_select)
        |=> !pc_q.powerdown_select) else $error("power-down select set with watchdog on");
    a_pd_precedence: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_hit && wv.powerdown_select && wv.idle_select && !watchdog_enable_i
         && mode_q == MODE_RUN)
        |=> ##1 mode_q == MODE_POWERDOWN) else $error("idle taken over power-down");
    a_wle_clear_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
        watchdog_timer_load_i |=> !pc_q.watchdog_load_enable) else $error("load enable kept");
    a_pof_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
        power_up_detect_i |=> pc_q.power_off_flag) else $error("power-off flag not set");
    a_baud_double: assert property (@(posedge clk_i) disable iff (!rstn_i)
        baud_double_o |-> $past(pc_q.baud_double) && $past(serial_mode_i) != 2'b00)
        else $error("baud doubled wrongly");
    a_ram_guard: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode_q == MODE_IDLE && hw_reset_req_i) |=> ram_write_block_o [*2])
        else $error("RAM writes not blocked");
    a_emul_pins: assert property (@(posedge clk_i) disable iff (!rstn_i)
        emulation_o |-> port0_float_o && weak_pullup_o && !osc_stop_o)
        else $error("emulation pin state wrong");
    a_strobe_ext: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ext_mem_access_i && !emul_w) |=> latch_strobe_en_o) else $error("strobe not driven");
    a_idle_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode_q == MODE_IDLE && interrupt_pending_i) |=> mode_q == MODE_RUN)
        else $error("idle not left on interrupt");
    a_pd_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode_q == MODE_POWERDOWN && ext_interrupt_i && !powerdown_wake_enable_i)
        |=> mode_q == MODE_POWERDOWN) else $error("power-down left without wake enable");
endmodule : power_mode_control
`default_nettype wire

// ---- verification/emulator_probe.sv ----
/*
 * Emulator side model that drives the entry strobes around reset.
 * Assumes clk_i and rstn_i are shared with the power and mode control.
 */
`timescale 1ns/1ps
`default_nettype none
module emulator_probe (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic enter_i,
    output var  logic latch_strobe_o,
    output var  logic program_store_strobe_o
);
    logic [1:0] hold_q;

    // Counts three edges past reset release so the strobe is held low across the sample.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_q <= 2'h3;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    // Outside the entry window both strobes rest at their pulled-up level.
    assign latch_strobe_o = !(enter_i && (!rstn_i || hold_q != 2'h0));
    assign program_store_strobe_o = 1'b1;
endmodule : emulator_probe
`default_nettype wire

// ---- verification/tb_power_mode_control.sv ----
/*
 * Self-checking bench for the power and mode control.
 * Assumes the package, map header and the emulator model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_control;
    import power_mode_pkg::*;
    logic clk_i = 1'b0;
    logic rstn = 1'b0;
    sfr_req_s sfr = '0;
    logic watchdog_enable = 1'b0, wake = 1'b0, wload = 1'b0, pup = 1'b0, irq = 1'b0, xirq = 1'b0;
    logic hwreq = 1'b0, aoff = 1'b0, xmem = 1'b0, enter = 1'b0;
    logic [1:0] smode = 2'h0;
    logic ls, pss, hit, baud, ser7, halt, osc, ramb, emu, p0f, wpu, len;
    logic [7:0] rdata;
    logic [7:0] mode;
    logic [7:0] misc;
    int checks = 0;
    int mismatches = 0;

    // Groups the mode outputs and the miscellaneous outputs for compact compares.
    assign mode = {3'h0, emu, p0f, wpu, halt, osc};
    assign misc = {4'h0, ramb, len, baud, ser7};

    // 50 MHz clock.
    always #10 clk_i = ~clk_i;

    emulator_probe probe_u (.clk_i(clk_i), .rstn_i(rstn), .enter_i(enter),
        .latch_strobe_o(ls), .program_store_strobe_o(pss));

    power_mode_control #(.IDLE_GUARD(4)) dut_u (.clk_i(clk_i), .rstn_i(rstn), .sfr_i(sfr),
        .sfr_rdata_o(rdata), .sfr_hit_o(hit), .watchdog_enable_i(watchdog_enable),
        .powerdown_wake_enable_i(wake), .watchdog_timer_load_i(wload),
        .power_up_detect_i(pup), .interrupt_pending_i(irq), .ext_interrupt_i(xirq),
        .hw_reset_req_i(hwreq), .latch_strobe_off_i(aoff), .ext_mem_access_i(xmem),
        .latch_strobe_i(ls), .program_store_strobe_i(pss), .serial_mode_i(smode),
        .baud_double_o(baud), .serial_bit7_select_o(ser7), .cpu_halt_o(halt),
        .osc_stop_o(osc), .ram_write_block_o(ramb), .emulation_o(emu),
        .port0_float_o(p0f), .weak_pullup_o(wpu), .latch_strobe_en_o(len));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task automatic wr(input logic [7:0] d);
        @(negedge clk_i);
        sfr = '{1'b1, 1'b1, 8'h87, d};
        @(negedge clk_i);
        sfr = '0;
    endtask : wr

    // Reads one address and compares the data and the hit pulse.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        sfr = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk_i);
        sfr = '0;
        check(rdata, exp);
        check({7'h0, hit}, {7'h0, a == 8'h87});
    endtask : rd

    task automatic pulse_reset(input logic em);
        enter = em;
        rstn = 1'b0;
        cyc(10);
        rstn = 1'b1;
        cyc(3);
        enter = 1'b0;
    endtask : pulse_reset

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Cuts a hung run short.
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        pulse_reset(1'b0);
        rd(8'h87, 8'h00);
        rd(8'h80, 8'h00);
        check(mode, 8'h00);
        wr(8'h0C);
        rd(8'h87, 8'h0C);
        smode = 2'h1;
        wr(8'hC0);
        cyc(2);
        check(misc, 8'h07);
        smode = 2'h2;
        cyc(2);
        check(misc, 8'h07);
        smode = 2'h3;
        cyc(2);
        check(misc, 8'h07);
        smode = 2'h0;
        aoff = 1'b1;
        cyc(2);
        check(misc, 8'h01);
        xmem = 1'b1;
        cyc(2);
        check(misc, 8'h05);
        xmem = 1'b0;
        aoff = 1'b0;
        wr(8'h10);
        rd(8'h87, 8'h10);
        wload = 1'b1;
        cyc(1);
        wload = 1'b0;
        rd(8'h87, 8'h00);
        pup = 1'b1;
        cyc(1);
        pup = 1'b0;
        rd(8'h87, 8'h20);
        wr(8'h00);
        rd(8'h87, 8'h00);
        watchdog_enable = 1'b1;
        wr(8'h02);
        cyc(3);
        rd(8'h87, 8'h00);
        check(mode, 8'h00);
        watchdog_enable = 1'b0;
        wr(8'h03);
        cyc(3);
        check(mode, 8'h03);
        rd(8'h87, 8'h02);
        xirq = 1'b1;
        cyc(4);
        check(mode, 8'h03);
        wake = 1'b1;
        cyc(4);
        check(mode, 8'h00);
        xirq = 1'b0;
        wake = 1'b0;
        rd(8'h87, 8'h00);
        wr(8'h01);
        cyc(3);
        check(mode, 8'h02);
        irq = 1'b1;
        cyc(3);
        check(mode, 8'h00);
        irq = 1'b0;
        rd(8'h87, 8'h00);
        // Idle entry is followed by a hardware reset request, with the RAM write guard checked.
        wr(8'h01);
        cyc(3);
        hwreq = 1'b1;
        cyc(2);
        check(misc, 8'h0C);
        hwreq = 1'b0;
        cyc(8);
        check(misc, 8'h04);
        pulse_reset(1'b0);
        rd(8'h87, 8'h00);
        pulse_reset(1'b1);
        check(mode, 8'h1C);
        pulse_reset(1'b0);
        check(mode, 8'h00);
        stop_test();
    end
endmodule : tb_power_mode_control
`default_nettype wire
